// ==== common/dxr_pkg.sv ====
// constants shared by the receiver error report and hsync configuration block
`default_nettype none
package dxr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ERR_COUNT = 8'h29;
  localparam logic [7:0] IDX_VC_DTYPE = 8'h2A;
  localparam logic [7:0] IDX_PKT_RPT = 8'h2B;
  localparam logic [7:0] IDX_LANE_RPT = 8'h2C;
  localparam logic [7:0] IDX_CMD_RPT = 8'h2D;
  localparam logic [7:0] IDX_HSW_HI = 8'h30;
  localparam logic [7:0] IDX_HSW_LO = 8'h31;
  localparam logic [7:0] IDX_EN_PKT = 8'h40;
  localparam logic [7:0] IDX_EN_LANE = 8'h41;
  localparam logic [7:0] IDX_EN_CMD = 8'h42;
  localparam logic [7:0] IDX_CTRL = 8'h43;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h44;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h45;
  // implemented bits of each report layout
  localparam logic [7:0] PKT_MASK = 8'hBF;
  localparam logic [7:0] LANE_MASK = 8'h7F;
  localparam logic [7:0] CMD_MASK = 8'h07;
  localparam logic [1:0] HSW_HI_MASK = 2'h3;
  // reset values
  localparam logic [7:0] EN_PKT_RST = 8'hBF;
  localparam logic [7:0] EN_LANE_RST = 8'h7F;
  localparam logic [7:0] EN_CMD_RST = 8'h07;
  localparam logic [1:0] HSW_HI_RST = 2'h0;
  localparam logic [7:0] HSW_LO_RST = 8'h20;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // field positions
  localparam int CMD_MISSING_EOT_BIT = 1;
  localparam int CTRL_SYNC_PULSE_BIT = 0;
  localparam int CTRL_EOT_OPT_BIT = 1;
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_HDR_BIT = 1;
  localparam int IRQ_SAT_BIT = 2;
  localparam int IRQ_W = 3;
  // pixel stream data type window on the low nibble
  localparam logic [3:0] DT_LO_MIN = 4'hB;
  localparam logic [3:0] DT_LO_MAX = 4'hE;
endpackage
`default_nettype wire

// ==== design/dxr_sync.sv ====
// two flip-flop synchroniser for a bundle of levels from outside the clock domain
`default_nettype none
module dxr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule
`default_nettype wire

// ==== design/dxr_sticky.sv ====
// sticky flag bank: set by events, cleared as a whole, set wins over clear
`default_nettype none
module dxr_sticky #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // events and clear
  input wire logic [W-1:0] set_i,
  input wire logic clr_i,
  output logic [W-1:0] flags_o
);
  logic [W-1:0] flags_reg;

  // an event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_reg <= '0;
    end else if (ce_i) begin
      flags_reg <= (clr_i ? '0 : flags_reg) | set_i;
    end
  end

  assign flags_o = flags_reg;
endmodule
`default_nettype wire

// ==== design/dxr_regs.sv ====
// receiver error report, last packet capture and hsync width registers on wishbone
// What this block does
// - 8-bit error count, cleared by reading it
// - capture channel id when type nibble B..E
// - capture data type under same nibble window
// - packet error report bit layout
// - lane error report bit layout
// - command error report bit layout
// - 10-bit hsync width, low byte resets 20h
// - width applies only in sync-event mode
// - causes count only when enabled, enables reset one
// - missing end packet flagged only mode clear
`default_nettype none
module dxr_regs
  import dxr_pkg::*;
(
  // system clock, reset, clock enable
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link side, all sampled on link clock rising edges
  input wire logic link_clk_i,
  input wire logic hdr_valid_i,
  input wire logic [1:0] hdr_vc_i,
  input wire logic [5:0] hdr_dt_i,
  input wire logic [7:0] pkt_err_i,
  input wire logic [7:0] lane_err_i,
  input wire logic [7:0] cmd_err_i,
  input wire logic line_start_i,
  // generated sync and interrupt
  output logic hsync_o,
  output logic irq_o
);
  import dxr_pkg::*;
  localparam int SW = 1 + 1 + 2 + 6 + 8 + 8 + 8 + 1;
  typedef enum logic {
    DXR_HS_IDLE,
    DXR_HS_PULSE
  } dxr_hs_e;
  // synchronised link signals
  logic [SW-1:0] link_sync;
  logic lclk_s;
  logic hdr_valid_s;
  logic [1:0] hdr_vc_s;
  logic [5:0] hdr_dt_s;
  logic [7:0] pkt_err_s;
  logic [7:0] lane_err_s;
  logic [7:0] cmd_err_s;
  logic line_start_s;
  logic lclk_prev_reg;
  logic lclk_rise;
  logic line_prev_reg;
  // wishbone
  logic wb_req;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [7:0] idx;
  logic rd_take;
  logic wr_take;
  logic [7:0] rd_val;
  // configuration
  logic [1:0] hsw_hi_reg;
  logic [7:0] hsw_lo_reg;
  logic [7:0] en_pkt_reg;
  logic [7:0] en_lane_reg;
  logic [7:0] en_cmd_reg;
  logic sync_pulse_mode_reg;
  logic end_packet_optional_mode_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  // status
  logic [7:0] err_cnt_reg;
  logic [7:0] err_cnt_next;
  logic [1:0] last_virtual_channel_reg;
  logic [5:0] last_data_type_reg;
  logic [7:0] pkt_rpt;
  logic [7:0] lane_rpt;
  logic [7:0] cmd_rpt;
  logic [IRQ_W-1:0] irq_stat;
  logic [7:0] pkt_set;
  logic [7:0] lane_set;
  logic [7:0] cmd_set;
  logic [IRQ_W-1:0] irq_set;
  logic err_event;
  logic hdr_take;
  logic cnt_clr;
  // hsync generator
  dxr_hs_e hs_state_reg;
  logic [9:0] hs_left_reg;
  logic hsync_reg;
  logic [9:0] hsync_width;
  // every link input, link clock included, crosses on two flops
  dxr_sync #(
    .W(SW)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i({link_clk_i, hdr_valid_i, hdr_vc_i, hdr_dt_i, pkt_err_i, lane_err_i, cmd_err_i, line_start_i}),
    .q_o(link_sync)
  );

  assign {lclk_s, hdr_valid_s, hdr_vc_s, hdr_dt_s, pkt_err_s, lane_err_s, cmd_err_s, line_start_s} = link_sync;
  // link clock edge finder on the synchronised copy
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lclk_prev_reg <= 1'b0;
    end else if (ce_i) begin
      lclk_prev_reg <= lclk_s;
    end
  end

  // data and clock share the same two stages, so they stay aligned
  assign lclk_rise = lclk_s & ~lclk_prev_reg;
  // wishbone request decode; answer one cycle after the request is seen
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign idx = wb_adr_i[9:2];
  assign rd_take = wb_req & ~wb_we_i;
  assign wr_take = wb_req & wb_we_i & wb_sel_i[0];

  // read mux; unmapped indices read as zero
  always_comb begin
    rd_val = 8'h00;
    if (idx == IDX_ERR_COUNT) begin
      rd_val = err_cnt_reg;
    end else if (idx == IDX_VC_DTYPE) begin
      rd_val = {last_virtual_channel_reg, last_data_type_reg};
    end else if (idx == IDX_PKT_RPT) begin
      rd_val = pkt_rpt;
    end else if (idx == IDX_LANE_RPT) begin
      rd_val = lane_rpt;
    end else if (idx == IDX_CMD_RPT) begin
      rd_val = cmd_rpt;
    end else if (idx == IDX_HSW_HI) begin
      rd_val = {6'h00, hsw_hi_reg};
    end else if (idx == IDX_HSW_LO) begin
      rd_val = hsw_lo_reg;
    end else if (idx == IDX_EN_PKT) begin
      rd_val = en_pkt_reg;
    end else if (idx == IDX_EN_LANE) begin
      rd_val = en_lane_reg;
    end else if (idx == IDX_EN_CMD) begin
      rd_val = en_cmd_reg;
    end else if (idx == IDX_CTRL) begin
      rd_val = {6'h00, end_packet_optional_mode_reg, sync_pulse_mode_reg};
    end else if (idx == IDX_IRQ_STAT) begin
      rd_val = {5'h00, irq_stat};
    end else if (idx == IDX_IRQ_MASK) begin
      rd_val = {5'h00, irq_mask_reg};
    end
  end

  // ack and read data; every address is answered, writes to read-only ones are dropped
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= wb_req;
      if (rd_take) begin
        dat_reg <= {24'h00_0000, rd_val};
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  // width and enables are software written
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hsw_hi_reg <= HSW_HI_RST;
      hsw_lo_reg <= HSW_LO_RST;
      en_pkt_reg <= EN_PKT_RST;
      en_lane_reg <= EN_LANE_RST;
      en_cmd_reg <= EN_CMD_RST;
      sync_pulse_mode_reg <= 1'b0;
      end_packet_optional_mode_reg <= 1'b0;
      irq_mask_reg <= '0;
    end else if (ce_i && wr_take) begin
      if (idx == IDX_HSW_HI) begin
        hsw_hi_reg <= wb_dat_i[1:0] & HSW_HI_MASK;
      end else if (idx == IDX_HSW_LO) begin
        hsw_lo_reg <= wb_dat_i[7:0];
      end else if (idx == IDX_EN_PKT) begin
        en_pkt_reg <= wb_dat_i[7:0] & PKT_MASK;
      end else if (idx == IDX_EN_LANE) begin
        en_lane_reg <= wb_dat_i[7:0] & LANE_MASK;
      end else if (idx == IDX_EN_CMD) begin
        en_cmd_reg <= wb_dat_i[7:0] & CMD_MASK;
      end else if (idx == IDX_CTRL) begin
        sync_pulse_mode_reg <= wb_dat_i[CTRL_SYNC_PULSE_BIT];
        end_packet_optional_mode_reg <= wb_dat_i[CTRL_EOT_OPT_BIT];
      end else if (idx == IDX_IRQ_MASK) begin
        irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // raw causes, sampled once per link clock edge
  always_comb begin
    pkt_set = 8'h00;
    lane_set = 8'h00;
    cmd_set = 8'h00;
    if (lclk_rise) begin
      // packet layout, reserved bit 6 never sets
      pkt_set = pkt_err_s & PKT_MASK;
      lane_set = lane_err_s & LANE_MASK;
      // command layout, bits 7..3 never set
      cmd_set = cmd_err_s & CMD_MASK;
      // suppressed while the end packet is optional
      if (end_packet_optional_mode_reg) begin
        cmd_set[CMD_MISSING_EOT_BIT] = 1'b0;
      end
    end
  end

  // only enabled causes reach the aggregate
  assign err_event = |{pkt_set & en_pkt_reg, lane_set & en_lane_reg, cmd_set & en_cmd_reg};
  // report banks clear on a read of their own register
  dxr_sticky #(
    .W(8)
  ) u_pkt_rpt (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .set_i(pkt_set),
    .clr_i(rd_take && idx == IDX_PKT_RPT),
    .flags_o(pkt_rpt)
  );
  dxr_sticky #(
    .W(8)
  ) u_lane_rpt (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .set_i(lane_set),
    .clr_i(rd_take && idx == IDX_LANE_RPT),
    .flags_o(lane_rpt)
  );
  dxr_sticky #(
    .W(8)
  ) u_cmd_rpt (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .set_i(cmd_set),
    .clr_i(rd_take && idx == IDX_CMD_RPT),
    .flags_o(cmd_rpt)
  );

  // count one per enabled event, hold at the top
  always_comb begin
    cnt_clr = rd_take && idx == IDX_ERR_COUNT;
    err_cnt_next = cnt_clr ? CNT_RST : err_cnt_reg;
    if (err_event && err_cnt_next != CNT_MAX) begin
      err_cnt_next = err_cnt_next + 8'h01;
    end
  end

  // read returns the count then zeroes it; an event in that cycle starts at one
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_cnt_reg <= CNT_RST;
    end else if (ce_i) begin
      err_cnt_reg <= err_cnt_next;
    end
  end

  // only pixel stream headers update the capture
  assign hdr_take = lclk_rise & hdr_valid_s & (hdr_dt_s[3:0] >= DT_LO_MIN) & (hdr_dt_s[3:0] <= DT_LO_MAX);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_virtual_channel_reg <= 2'h0;
      last_data_type_reg <= 6'h00;
    end else if (ce_i && hdr_take) begin
      last_virtual_channel_reg <= hdr_vc_s;
      last_data_type_reg <= hdr_dt_s;
    end
  end

  // interrupt sources: enabled error, header capture, counter stuck at top
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_ERR_BIT] = err_event;
    irq_set[IRQ_HDR_BIT] = hdr_take;
    irq_set[IRQ_SAT_BIT] = err_event && err_cnt_reg == CNT_MAX;
  end
  dxr_sticky #(
    .W(IRQ_W)
  ) u_irq (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .set_i(irq_set),
    .clr_i(rd_take && idx == IDX_IRQ_STAT),
    .flags_o(irq_stat)
  );

  // level interrupt straight from the sticky bits
  assign irq_o = |(irq_stat & irq_mask_reg);
  // the two halves join into one width
  assign hsync_width = {hsw_hi_reg, hsw_lo_reg};
  // line start edge, seen only on link clock edges
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_prev_reg <= 1'b0;
    end else if (ce_i && lclk_rise) begin
      line_prev_reg <= line_start_s;
    end
  end

  // width counted in pixel clocks, sync-event mode only
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hs_state_reg <= DXR_HS_IDLE;
      hs_left_reg <= 10'h000;
      hsync_reg <= 1'b0;
    end else if (ce_i) begin
      if (sync_pulse_mode_reg) begin
        // pulse mode: the source shapes hsync itself
        hs_state_reg <= DXR_HS_IDLE;
        hs_left_reg <= 10'h000;
        if (lclk_rise) begin
          hsync_reg <= line_start_s;
        end
      end else if (lclk_rise) begin
        case (hs_state_reg)
          DXR_HS_IDLE: begin
            hsync_reg <= 1'b0;
            // zero width gives no pulse at all
            if (line_start_s && !line_prev_reg && hsync_width != 10'h000) begin
              hsync_reg <= 1'b1;
              hs_left_reg <= hsync_width - 10'h001;
              hs_state_reg <= DXR_HS_PULSE;
            end
          end
          DXR_HS_PULSE: begin
            if (hs_left_reg == 10'h000) begin
              hsync_reg <= 1'b0;
              hs_state_reg <= DXR_HS_IDLE;
            end else begin
              hs_left_reg <= hs_left_reg - 10'h001;
            end
          end
          default: begin
            hs_state_reg <= DXR_HS_IDLE;
          end
        endcase
      end
    end
  end

  assign hsync_o = hsync_reg;
endmodule
`default_nettype wire

// ==== verif/dxr_regs_monitor.sv ====
// port checker for the receiver error report block
`default_nettype none
module dxr_regs_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // bus and outputs
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic hsync_o,
  input wire logic irq_o
);
  // one domain, so clock and reset are shared
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // bus handshake
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_no_stray; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_no_stray: assert property (p_no_stray) else $error("ack without request");
  // read data only moves on a read answer
  property p_dat_hold; $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved outside a read");
  property p_hi_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
  // interrupt drops only through a bus access
  property p_irq_fall; $fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
  property p_irq_rst; $rose(rst_b_i) |-> !irq_o; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("interrupt high after reset");
  property p_hsync_rst; $rose(rst_b_i) |-> !hsync_o; endproperty
  a_hsync_rst: assert property (p_hsync_rst) else $error("hsync high after reset");
endmodule
bind dxr_regs dxr_regs_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .hsync_o(hsync_o), .irq_o(irq_o));
`default_nettype wire

// ==== verif/dxr_src_model.sv ====
// video source model driving the link side
`default_nettype none
module dxr_src_model (
  // link outputs
  output var logic link_clk_o,
  output var logic hdr_valid_o,
  output var logic [1:0] hdr_vc_o,
  output var logic [5:0] hdr_dt_o,
  output var logic [7:0] pkt_err_o,
  output var logic [7:0] lane_err_o,
  output var logic [7:0] cmd_err_o,
  output var logic line_start_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // pixel clock, phase offset from the system clock
  initial begin
    link_clk_o = 1'b0;
    {hdr_valid_o, hdr_vc_o, hdr_dt_o, pkt_err_o, lane_err_o, cmd_err_o, line_start_o} = '0;
    #7;
    forever #80 link_clk_o = ~link_clk_o;
  end
  // one beat: held over a single rising edge, changed on falling edges
  task automatic beat(input logic hv, input logic [7:0] vcdt, input logic [7:0] pe, le, ce, input logic ls);
    @(negedge link_clk_o);
    hdr_valid_o = hv;
    {hdr_vc_o, hdr_dt_o} = vcdt;
    {pkt_err_o, lane_err_o, cmd_err_o, line_start_o} = {pe, le, ce, ls};
    @(negedge link_clk_o);
    hdr_valid_o = 1'b0;
    {hdr_vc_o, hdr_dt_o} = ~vcdt; // stale header must not be trusted
    {pkt_err_o, lane_err_o, cmd_err_o, line_start_o} = '0;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the receiver error report block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dxr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic ack, irq, hsync, lclk, hv, ls;
  logic [1:0] vc;
  logic [5:0] dt;
  logic [7:0] pe, le, cm;
  logic [7:0] hdr [4] = '{8'hAE, 8'h4A, 8'hFB, 8'h4F};
  logic [7:0] cap [4] = '{8'hAE, 8'hAE, 8'hFB, 8'hFB};
  int n_fail = 0;
  int cmp_count = 0;
  // 50 MHz system clock
  always #10 clk_sys_i = ~clk_sys_i;
  dxr_regs DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link_clk_i(lclk), .hdr_valid_i(hv), .hdr_vc_i(vc), .hdr_dt_i(dt), .pkt_err_i(pe), .lane_err_i(le),
    .cmd_err_i(cm), .line_start_i(ls), .hsync_o(hsync), .irq_o(irq));
  dxr_src_model src (.link_clk_o(lclk), .hdr_valid_o(hv), .hdr_vc_o(vc), .hdr_dt_o(dt), .pkt_err_o(pe),
    .lane_err_o(le), .cmd_err_o(cm), .line_start_o(ls));
  // compare and count
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] idx, d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    r = rdat;
    {cyc, stb, we} <= 3'b000;
    if (ack !== 1'b1) n_fail++;
  endtask
  task automatic wr(input logic [7:0] idx, d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rd(input logic [7:0] idx, exp);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r, {24'h0, exp});
  endtask
  // link beat, then time for the synchroniser
  task automatic ev(input logic h, input logic [7:0] vd, p, l, c);
    src.beat(h, vd, p, l, c, 1'b0);
    repeat (6) @(posedge clk_sys_i);
  endtask
  // count system cycles with hsync high around one line start
  task automatic hs(input int exp);
    int n;
    n = 0;
    fork
      src.beat(1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
      repeat (exp + 64) begin
        @(posedge clk_sys_i);
        n += (hsync === 1'b1);
      end
    join
    chk(n, exp);
  endtask
  task automatic t_reset;
    rd(IDX_ERR_COUNT, 8'h00);
    rd(IDX_HSW_HI, 8'h00);
    rd(IDX_HSW_LO, 8'h20);
    rd(IDX_EN_PKT, 8'hBF);
    rd(IDX_EN_LANE, 8'h7F);
    rd(IDX_EN_CMD, 8'h07);
    wr(IDX_PKT_RPT, 8'hFF);
    rd(IDX_PKT_RPT, 8'h00);
    rd(8'h3F, 8'h00);
  endtask
  task automatic t_report;
    ev(1'b0, 8'h00, 8'hFF, 8'hFF, 8'hFF);
    rd(IDX_ERR_COUNT, 8'h01);
    rd(IDX_ERR_COUNT, 8'h00);
    rd(IDX_PKT_RPT, 8'hBF);
    rd(IDX_LANE_RPT, 8'h7F);
    rd(IDX_CMD_RPT, 8'h07);
    rd(IDX_PKT_RPT, 8'h00);
  endtask
  task automatic t_irq;
    rd(IDX_IRQ_STAT, 8'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    ev(1'b0, 8'h00, 8'h04, 8'h00, 8'h00);
    chk({31'h0, irq}, 32'h1);
    rd(IDX_IRQ_STAT, 8'h01);
    chk({31'h0, irq}, 32'h0);
    // stop counting before an exact read
    for (int i = 0; i < 3; i++) wr(IDX_EN_PKT + 8'(i), 8'h00);
    rd(IDX_ERR_COUNT, 8'h01);
    ev(1'b0, 8'h00, 8'h04, 8'h00, 8'h00);
    rd(IDX_ERR_COUNT, 8'h00);
    chk({31'h0, irq}, 32'h0);
    rd(IDX_PKT_RPT, 8'h04);
    wr(IDX_EN_PKT, 8'hBF);
    wr(IDX_EN_LANE, 8'h7F);
    wr(IDX_EN_CMD, 8'h07);
  endtask
  task automatic t_eot;
    wr(IDX_CTRL, 8'h02);
    ev(1'b0, 8'h00, 8'h00, 8'h00, 8'h02);
    rd(IDX_CMD_RPT, 8'h00);
    wr(IDX_CTRL, 8'h00);
    ev(1'b0, 8'h00, 8'h00, 8'h00, 8'h02);
    rd(IDX_CMD_RPT, 8'h02);
  endtask
  task automatic t_capture;
    for (int i = 0; i < 4; i++) begin
      ev(1'b1, hdr[i], 8'h00, 8'h00, 8'h00);
      rd(IDX_VC_DTYPE, cap[i]);
    end
    // enabled error from the end packet case plus header capture
    rd(IDX_IRQ_STAT, 8'h03);
  endtask
  // frozen clock enable: a link error must leave no trace
  task automatic t_freeze;
    @(posedge clk_sys_i);
    ce <= 1'b0;
    ev(1'b0, 8'h00, 8'h04, 8'h00, 8'h00);
    @(posedge clk_sys_i);
    ce <= 1'b1;
    rd(IDX_ERR_COUNT, 8'h01);
    rd(IDX_PKT_RPT, 8'h00);
  endtask
  task automatic t_saturate;
    repeat (260) src.beat(1'b0, 8'h00, 8'h01, 8'h00, 8'h00, 1'b0);
    repeat (6) @(posedge clk_sys_i);
    rd(IDX_ERR_COUNT, 8'hFF);
    // errors kept arriving while the count sat at the top
    rd(IDX_IRQ_STAT, 8'h05);
  endtask
  task automatic t_hsync;
    wr(IDX_HSW_LO, 8'h03);
    hs(24);
    wr(IDX_HSW_HI, 8'h01);
    wr(IDX_HSW_LO, 8'h00);
    rd(IDX_HSW_HI, 8'h01);
    hs(2048);
    wr(IDX_CTRL, 8'h01);
    hs(8);
  endtask
  // verdict and end of run
  task automatic complete_run;
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_reset;
    t_report;
    t_irq;
    t_eot;
    t_capture;
    t_freeze;
    t_saturate;
    t_hsync;
    complete_run;
  end
  // watchdog, well beyond the expected run
  initial begin
    #1000000;
    n_fail++;
    complete_run;
  end
endmodule
`default_nettype wire
